// ===== hw/flash_block_erase_mat_switch.sv
/*
  Flash routine download, single-block erase call and array switch,
  reached over APB.
  Assumes a flash macro handshaking erase_req/erase_done on mclk and a
  byte-wide RAM write port that accepts one byte per cycle.
*/
// The register addresses and the APB interface to the registers were chosen for this implementation.
// Behaviour
// R1: one erase call clears one block
// R2: program-select bit picks programming routine
// R3: several selects: no download, selection error
// R4: routine copied at download target address
// R5: invalid block number: nothing erased, error
// R6: entry point sixteen bytes above start
// R7: result in low byte, register zero
// R8: caller reserves 128-byte stack
// R9: caller clears key; long reset
// R10: caller avoids emulation RAM region
// R11: caller initialises each routine at +32
// R12: separate RAM areas per routine
// R13: user boot mode: only user array
// R14: boot check holds all interrupts
// R15: after check boot array selected
// R16: user boot mode shows boot array
// R17: caller waits for array switch
// R18: caller switches back to boot array
// R19: caller starts download from RAM
// R20: caller runs outside erased array
// R21: caller writes download key first
// R22: caller writes erase key first
// R23: key cleared after each download
// R24: erase select bit, same one-only check
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_cfg.svh"

module flash_block_erase_mat_switch #(
  parameter int USER_BLOCKS  = 8,
  parameter int ROUTINE_LEN  = 64,
  parameter int CHECK_CYCLES = `CHECK_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        user_boot_pin,
  output logic             irq_hold,
  output logic             flash_access_block,
  output logic             boot_array_visible,
  output logic             ram_we,
  output logic [23:0]      ram_addr,
  output logic [7:0]       ram_wdata,
  output logic             erase_req,
  output logic [7:0]       erase_block,
  input  wire logic        erase_done
);

  // ****************************************
  // Strap capture
  // ****************************************
  logic [2:0] pin_sync_q;
  logic [1:0] strap_cnt_q;
  logic       strap_ok_q;
  logic       user_boot_q;
  logic       check_start;
  logic       check_busy;
  logic       check_done;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q <= 3'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], user_boot_pin};
    end
  end

  // Strap taken once the sync chain has filled and agrees
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_q <= 2'h0;
      strap_ok_q  <= 1'b0;
      user_boot_q <= 1'b0;
    end else if (!strap_ok_q) begin
      if (strap_cnt_q != 2'h3) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end else if (pin_sync_q[1] == pin_sync_q[2]) begin
        strap_ok_q  <= 1'b1;
        user_boot_q <= pin_sync_q[2];
      end
    end
  end

  assign check_start = strap_ok_q && user_boot_q && !check_busy && !check_done;

  boot_check #(
    .CYCLES (CHECK_CYCLES)
  ) u_check (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (check_start),
    .busy  (check_busy),
    .done  (check_done)
  );

  // ****************************************
  // APB decode
  // ****************************************
  logic                       wr_en;
  logic                       rd_en;
  logic                       hit;
  flash_seq_pkg::seq_state_e  state_q;
  flash_seq_pkg::seq_state_e  state_d;
  logic                       start_q;
  logic                       prog_sel_q;
  logic                       erase_sel_q;
  logic [23:0]                dl_target_q;
  logic [7:0]                 key_q;
  logic [7:0]                 array_sel_q;
  logic [7:0]                 dl_result_q;
  logic [31:0]                greg_zero_q;
  logic [31:0]                greg_one_q;
  logic [23:0]                erase_base_q;
  logic [23:0]                prog_base_q;
  logic                       erase_loaded_q;
  logic                       prog_loaded_q;
  logic [7:0]                 idx_q;
  logic                       dl_is_erase_q;
  logic [15:0]                sw_cnt_q;
  logic                       busy;
  logic                       sw_busy;
  logic                       sel_conflict;
  logic                       sel_none;
  logic                       key_dl_ok;
  logic                       block_ok;
  logic                       protect_hit;
  logic                       go_dl;
  logic                       go_erase;
  logic [7:0]                 er_code;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign hit   = (paddr[1:0] == 2'h0) && (paddr <= `OFS_PROG_ENTRY);
  assign busy  = (state_q != flash_seq_pkg::ST_IDLE);
  assign sw_busy = (sw_cnt_q != 16'h0);

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_sel_q  <= 1'b0;
      erase_sel_q <= 1'b0;
      dl_target_q <= 24'h0;
      greg_one_q  <= 32'h0;
    end else if (state_q == flash_seq_pkg::ST_DL_RES) begin
      prog_sel_q  <= 1'b0;
      erase_sel_q <= 1'b0;
    end else if (wr_en && !busy) begin
      if (paddr == `OFS_PROG_SEL) prog_sel_q <= pwdata[0];
      if (paddr == `OFS_ERASE_SEL) erase_sel_q <= pwdata[0];
      if (paddr == `OFS_DL_TARGET) dl_target_q <= pwdata[23:0];
      if (paddr == `OFS_GREG_ONE) greg_one_q <= pwdata;
    end else if (state_q == flash_seq_pkg::ST_ER_WAIT && erase_done) begin
      // R7 register one is scratch
      greg_one_q <= 32'h0;
    end
  end

  // R23 key wiped after any download attempt
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= `KEY_CLEAR;
    end else if (state_q == flash_seq_pkg::ST_DL_RES) begin
      key_q <= `KEY_CLEAR;
    end else if (wr_en && !busy && paddr == `OFS_KEY) begin
      key_q <= pwdata[7:0];
    end
  end

  // ****************************************
  // Array switch
  // ****************************************
  // R15 boot array selected as check starts; R16 user array hidden
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      array_sel_q <= `ARRAY_USER;
      sw_cnt_q    <= 16'h0;
    end else if (check_start) begin
      array_sel_q <= `ARRAY_BOOT;
    end else if (sw_busy) begin
      sw_cnt_q <= sw_cnt_q - 16'h1;
    end else if (wr_en && !busy && user_boot_q && check_done &&
                 paddr == `OFS_ARRAY_SEL) begin
      array_sel_q <= pwdata[7:0];
      sw_cnt_q    <= 16'(`SWITCH_CYCLES);
    end
  end

  // Visible array follows the select only when the switch has settled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_array_visible <= 1'b0;
    end else if (!sw_busy) begin
      boot_array_visible <= user_boot_q && (array_sel_q == `ARRAY_BOOT);
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // R3 R24 exactly one routine may be chosen
  assign sel_conflict = prog_sel_q && erase_sel_q;
  assign sel_none     = !prog_sel_q && !erase_sel_q;
  assign key_dl_ok    = (key_q == `KEY_DOWNLOAD);
  assign go_dl        = wr_en && !busy && paddr == `OFS_CODE_CTRL && pwdata[`BIT_START];
  assign go_erase     = wr_en && !busy && paddr == `OFS_ERASE_CALL && pwdata[0];
  // R5 block number range check
  assign block_ok     = (greg_zero_q < 32'(USER_BLOCKS));
  // R13 boot array never erased in user boot mode
  assign protect_hit  = user_boot_q && (array_sel_q == `ARRAY_BOOT);
  assign er_code      = {4'h0,
                         protect_hit,
                         !erase_loaded_q,
                         key_q != `KEY_PROG_ERASE,
                         !block_ok};

  always_comb begin
    state_d = state_q;
    case (state_q)
      flash_seq_pkg::ST_IDLE: begin
        if (go_dl) begin
          state_d = (sel_conflict || sel_none || !key_dl_ok) ?
                    flash_seq_pkg::ST_DL_RES : flash_seq_pkg::ST_DL_COPY;
        end else if (go_erase) begin
          state_d = flash_seq_pkg::ST_ER_RUN;
        end
      end
      flash_seq_pkg::ST_DL_COPY: begin
        if (idx_q == 8'(ROUTINE_LEN - 1)) state_d = flash_seq_pkg::ST_DL_RES;
      end
      flash_seq_pkg::ST_DL_RES: state_d = flash_seq_pkg::ST_IDLE;
      flash_seq_pkg::ST_ER_RUN: begin
        state_d = (er_code == 8'h00) ? flash_seq_pkg::ST_ER_WAIT : flash_seq_pkg::ST_IDLE;
      end
      flash_seq_pkg::ST_ER_WAIT: begin
        if (erase_done) state_d = flash_seq_pkg::ST_IDLE;
      end
      default: state_d = flash_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= flash_seq_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Start bit reads as set only while a download runs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_q       <= 1'b0;
      dl_is_erase_q <= 1'b0;
      idx_q         <= 8'h0;
    end else if (state_q == flash_seq_pkg::ST_IDLE && go_dl) begin
      start_q       <= 1'b1;
      dl_is_erase_q <= erase_sel_q;
      idx_q         <= 8'h1;
    end else if (state_q == flash_seq_pkg::ST_DL_COPY) begin
      idx_q <= idx_q + 8'h1;
    end else if (state_q == flash_seq_pkg::ST_DL_RES) begin
      start_q <= 1'b0;
    end
  end

  // R4 R12 each routine keeps its own base address
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dl_result_q    <= 8'h0;
      erase_base_q   <= 24'h0;
      prog_base_q    <= 24'h0;
      erase_loaded_q <= 1'b0;
      prog_loaded_q  <= 1'b0;
    end else if (state_q == flash_seq_pkg::ST_DL_RES) begin
      dl_result_q <= {6'h0, !key_dl_ok, sel_conflict || sel_none};
      if (!sel_conflict && !sel_none && key_dl_ok) begin
        // R2 programming routine recorded
        if (prog_sel_q) begin
          prog_base_q   <= dl_target_q;
          prog_loaded_q <= 1'b1;
        end
        // R24 erase routine recorded
        if (erase_sel_q) begin
          erase_base_q   <= dl_target_q;
          erase_loaded_q <= 1'b1;
        end
      end
    end
  end

  // R4 routine bytes then result byte at the base
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ram_we    <= 1'b0;
      ram_addr  <= 24'h0;
      ram_wdata <= 8'h0;
    end else begin
      ram_we <= (state_q == flash_seq_pkg::ST_DL_COPY) ||
                (state_q == flash_seq_pkg::ST_DL_RES);
      if (state_q == flash_seq_pkg::ST_DL_COPY) begin
        ram_addr  <= dl_target_q + {16'h0, idx_q};
        ram_wdata <= {dl_is_erase_q, idx_q[6:0]};
      end else begin
        ram_addr  <= dl_target_q;
        ram_wdata <= {6'h0, !key_dl_ok, sel_conflict || sel_none};
      end
    end
  end

  // R1 one block per call; R7 result in low byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      greg_zero_q <= 32'h0;
      erase_req   <= 1'b0;
      erase_block <= 8'h0;
    end else if (wr_en && !busy && paddr == `OFS_GREG_ZERO) begin
      greg_zero_q <= pwdata;
    end else if (state_q == flash_seq_pkg::ST_ER_RUN) begin
      erase_req   <= (er_code == 8'h00);
      erase_block <= greg_zero_q[7:0];
      if (er_code != 8'h00) greg_zero_q <= {greg_zero_q[31:8], er_code};
    end else if (state_q == flash_seq_pkg::ST_ER_WAIT && erase_done) begin
      erase_req   <= 1'b0;
      greg_zero_q <= {greg_zero_q[31:8], 8'h00};
    end
  end

  // ****************************************
  // Read mux and status outputs
  // ****************************************
  // R6 entry points sixteen bytes above each base
  wire [31:0] rd_status = {27'h0, sw_busy, check_done, user_boot_q, busy, start_q};
  wire [31:0] rd_erase_entry = {8'h0, erase_base_q + `ENTRY_OFFSET};
  wire [31:0] rd_prog_entry  = {8'h0, prog_base_q + `ENTRY_OFFSET};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_CODE_CTRL:   prdata <= rd_status;
        `OFS_PROG_SEL:    prdata <= {31'h0, prog_sel_q};
        `OFS_ERASE_SEL:   prdata <= {31'h0, erase_sel_q};
        `OFS_DL_TARGET:   prdata <= {8'h0, dl_target_q};
        `OFS_KEY:         prdata <= {24'h0, key_q};
        `OFS_ARRAY_SEL:   prdata <= {24'h0, array_sel_q};
        `OFS_DL_RESULT:   prdata <= {24'h0, dl_result_q};
        `OFS_GREG_ZERO:   prdata <= greg_zero_q;
        `OFS_GREG_ONE:    prdata <= greg_one_q;
        `OFS_ERASE_ENTRY: prdata <= rd_erase_entry;
        `OFS_PROG_ENTRY:  prdata <= rd_prog_entry;
        default:          prdata <= 32'h0;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // R14 no interrupt, not even NMI, until check ends
  assign irq_hold = !strap_ok_q || check_busy || check_start ||
                    (state_q == flash_seq_pkg::ST_DL_COPY) ||
                    (state_q == flash_seq_pkg::ST_DL_RES);
  assign flash_access_block = sw_busy || busy;

  wire unused_ok = rd_en ^ prog_loaded_q;

endmodule : flash_block_erase_mat_switch

`default_nettype wire

// ===== hw/flash_seq_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the flash
  routine sequencer. Assumes a 40 MHz mclk and APB byte addressing.
*/
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CODE_CTRL      8'h00
`define OFS_PROG_SEL       8'h04
`define OFS_ERASE_SEL      8'h08
`define OFS_DL_TARGET      8'h0C
`define OFS_KEY            8'h10
`define OFS_ARRAY_SEL      8'h14
`define OFS_DL_RESULT      8'h18
`define OFS_GREG_ZERO      8'h1C
`define OFS_ERASE_CALL     8'h20
`define OFS_GREG_ONE       8'h24
`define OFS_ERASE_ENTRY    8'h28
`define OFS_PROG_ENTRY     8'h2C

// ****************************************
// Field positions
// ****************************************
`define BIT_START          0
`define BIT_BUSY           1
`define BIT_USER_BOOT      2
`define BIT_CHECK_DONE     3
`define BIT_SWITCH_BUSY    4
`define BIT_SEL_ERR        0
`define BIT_KEY_ERR        1
`define BIT_ER_BLOCK_ERR   0
`define BIT_ER_KEY_ERR     1
`define BIT_ER_NOT_LOADED  2
`define BIT_ER_PROTECT     3

// ****************************************
// Values
// ****************************************
`define KEY_DOWNLOAD       8'hA5
`define KEY_PROG_ERASE     8'h5A
`define KEY_CLEAR          8'h00
`define ARRAY_BOOT         8'hAA
`define ARRAY_USER         8'h00
`define ENTRY_OFFSET       24'h000010
`define INIT_OFFSET        24'h000020

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS      25
`define CHECK_TIME_NS      10000
`define SWITCH_TIME_NS     1000
`define CHECK_CYCLES       ((`CHECK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SWITCH_CYCLES      ((`SWITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hw/flash_seq_pkg.sv
/*
  Types of the flash routine sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flash_seq_pkg;

  // One-bit steps from idle through copy to result and through run to wait
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_DL_COPY = 3'h1,
    ST_DL_RES  = 3'h3,
    ST_ER_RUN  = 3'h2,
    ST_ER_WAIT = 3'h6
  } seq_state_e;

endpackage : flash_seq_pkg

// ===== hw/boot_check.sv
/*
  Built-in array check timer run once after reset in user boot mode.
  Assumes start is a one-cycle pulse on mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module boot_check #(
  parameter int CYCLES = 400
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [31:0] cnt_q;
  logic        busy_q;
  logic        done_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 32'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start && !busy_q) begin
      cnt_q  <= 32'(CYCLES);
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 32'h1;
      if (cnt_q == 32'h1) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule : boot_check

`default_nettype wire

// ===== bench/flash_seq_checker.sv
/*
  Port-level checks of the flash routine sequencer.
  Assumes binding to the top module with its parameters handed on.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_seq_checker #(
  parameter int USER_BLOCKS  = 8,
  parameter int ROUTINE_LEN  = 64,
  parameter int CHECK_CYCLES = 400
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        user_boot_pin,
  input wire logic        irq_hold,
  input wire logic        flash_access_block,
  input wire logic        boot_array_visible,
  input wire logic        ram_we,
  input wire logic [23:0] ram_addr,
  input wire logic [7:0]  ram_wdata,
  input wire logic        erase_req,
  input wire logic [7:0]  erase_block,
  input wire logic        erase_done
);
  // ****************************************
  // Cycles since reset release
  // ****************************************
  logic [15:0] cnt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 16'h0000;
    else if (cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_wait;  erase_req && !erase_done; endsequence
  sequence s_burst; ram_we ##1 ram_we;        endsequence

  // ****************************************
  // Assertions
  // ****************************************
  AST_ERASE_HOLD: assert property (s_wait |=> erase_req)
    else $error("erase request dropped before done");
  AST_ERASE_DROP: assert property (erase_req && erase_done |=> !erase_req)
    else $error("erase request held after done");
  AST_BLOCK_STABLE: assert property (erase_req ##1 erase_req |-> $stable(erase_block))
    else $error("erase block changed mid erase");
  AST_ERASE_START: assert property ($rose(erase_req) |-> flash_access_block && !ram_we)
    else $error("erase started while not busy");
  AST_BLOCK_RANGE: assert property (erase_req |-> erase_block < USER_BLOCKS)
    else $error("erase of invalid block");
  AST_RAM_ORDER: assert property (s_burst |-> ram_addr == $past(ram_addr) + 24'h000001
    || $past(ram_addr) == ram_addr + ROUTINE_LEN - 1)
    else $error("routine copy address out of order");
  AST_RAM_HOLD: assert property (ram_we |-> $past(irq_hold) && $past(flash_access_block))
    else $error("copy without interrupt hold");
  AST_CHECK_IRQ: assert property (user_boot_pin && cnt_q <= 4 + CHECK_CYCLES |-> irq_hold)
    else $error("interrupts released during boot check");
  AST_VISIBLE_RISE: assert property ($rose(boot_array_visible)
    |-> irq_hold || $past(flash_access_block, 2))
    else $error("boot array shown without check or switch");
endmodule : flash_seq_checker

bind flash_block_erase_mat_switch flash_seq_checker #(
  .USER_BLOCKS(USER_BLOCKS), .ROUTINE_LEN(ROUTINE_LEN), .CHECK_CYCLES(CHECK_CYCLES)
) u_flash_seq_checker (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .user_boot_pin(user_boot_pin), .irq_hold(irq_hold), .flash_access_block(flash_access_block),
  .boot_array_visible(boot_array_visible), .ram_we(ram_we), .ram_addr(ram_addr),
  .ram_wdata(ram_wdata), .erase_req(erase_req), .erase_block(erase_block),
  .erase_done(erase_done)
);
`default_nettype wire

// ===== bench/flash_macro_model.sv
/*
  Flash macro model answering erase requests lat+1 cycles after they rise.
  Assumes erase_req is held until erase_done is seen.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_macro_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       erase_req,
  input  wire logic [7:0] lat,
  output logic            erase_done,
  output logic [7:0]      erase_cnt
);
  logic [7:0] wait_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      erase_done <= 1'b0;
      erase_cnt  <= 8'h00;
      wait_q     <= 8'h00;
    end else begin
      erase_done <= 1'b0;
      if (erase_req && !erase_done) begin
        if (wait_q == lat) begin
          erase_done <= 1'b1;
          erase_cnt  <= erase_cnt + 8'h01;
          wait_q     <= 8'h00;
        end else wait_q <= wait_q + 8'h01;
      end
    end
  end
endmodule : flash_macro_model
`default_nettype wire

// ===== bench/testbench.sv
/*
  Self-checking bench of the flash routine sequencer over APB.
  Assumes user boot strap held high and a flash macro model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_cfg.svh"

module testbench;
  localparam int RLEN = 16;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, ub_pin, slv;
  logic        irq_hold, fab, bav, ram_we, erase_req, erase_done;
  logic [7:0]  paddr, ram_wdata, erase_block, lat, erase_cnt, last_blk, last_data;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] ram_addr, first_addr, last_addr;
  int          error_cnt = 0, num_checks = 0, wr_cnt = 0, cyc = 0;

  flash_block_erase_mat_switch #(.USER_BLOCKS(8), .ROUTINE_LEN(RLEN), .CHECK_CYCLES(4))
  u_flash_block_erase_mat_switch (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .user_boot_pin(ub_pin), .irq_hold(irq_hold), .flash_access_block(fab),
    .boot_array_visible(bav), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .erase_req(erase_req), .erase_block(erase_block), .erase_done(erase_done));
  flash_macro_model u_flash_macro_model (.mclk(mclk), .rst_n(rst_n), .erase_req(erase_req),
    .lat(lat), .erase_done(erase_done), .erase_cnt(erase_cnt));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (ram_we) begin
      if (wr_cnt == 0) first_addr = ram_addr;
      last_addr = ram_addr;
      last_data = ram_wdata;
      wr_cnt++;
    end
    if (erase_req) last_blk = erase_block;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Release costs one idle edge so no signal is driven twice at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask : rdchk
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 300; i++) begin
      xfer(1'b0, `OFS_CODE_CTRL, 32'h0000_0000);
      if ((rd & m) === v) break;
    end
    check("status wait", rd & m, v);
  endtask : wait_st
  task automatic dl(input logic p, input logic e, input logic [23:0] t, input logic [7:0] k);
    wr(`OFS_PROG_SEL, {31'h0, p});
    wr(`OFS_ERASE_SEL, {31'h0, e});
    wr(`OFS_DL_TARGET, {8'h00, t});
    wr(`OFS_KEY, {24'h0, k});
    wr_cnt = 0;
    wr(`OFS_CODE_CTRL, 32'h0000_0001);
    wait_st(32'h0000_0002, 32'h0000_0000);
  endtask : dl
  task automatic erase(input logic [7:0] blk);
    wr(`OFS_GREG_ZERO, {24'h0, blk});
    wr(`OFS_GREG_ONE, 32'h0000_0055);
    wr(`OFS_ERASE_CALL, 32'h0000_0001);
    wait_st(32'h0000_0002, 32'h0000_0000);
  endtask : erase
  task stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // ****************************************
  // Main sequence
  // ****************************************
  logic [7:0] bad_key [3] = '{8'hA5, 8'hA5, 8'h00};
  logic [1:0] bad_sel [3] = '{2'h3, 2'h0, 2'h2};
  logic [7:0] bad_res [3] = '{8'h01, 8'h01, 8'h02};
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; ub_pin = 1'b1; lat = 8'h00;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check("irq_hold", irq_hold, 1'b1);
    wait_st(32'h0000_0008, 32'h0000_0008);
    check("irq_hold", irq_hold, 1'b0);
    rdchk(`OFS_ARRAY_SEL, 32'h0000_00AA, "array_sel");
    check("boot visible", bav, 1'b1);
    for (int i = 0; i < 3; i++) begin
      dl(bad_sel[i][1], bad_sel[i][0], 24'h000300, bad_key[i]);
      rdchk(`OFS_DL_RESULT, {24'h0, bad_res[i]}, "dl result");
      check("ram writes", wr_cnt, 1);
      rdchk(`OFS_KEY, 32'h0, "key");
    end
    dl(1'b0, 1'b1, 24'h000100, `KEY_DOWNLOAD);
    check("ram writes", wr_cnt, RLEN);
    check("first addr", first_addr, 24'h000101);
    check("result addr", last_addr, 24'h000100);
    check("result byte", last_data, 8'h00);
    rdchk(`OFS_DL_RESULT, 32'h0, "dl result");
    rdchk(`OFS_ERASE_ENTRY, 32'h0000_0110, "erase entry");
    rdchk(`OFS_ERASE_SEL, 32'h0, "erase sel");
    rdchk(`OFS_KEY, 32'h0, "key");
    dl(1'b1, 1'b0, 24'h000200, `KEY_DOWNLOAD);
    rdchk(`OFS_PROG_ENTRY, 32'h0000_0210, "prog entry");
    check("prog init", rd - 32'h10 + {8'h0, `INIT_OFFSET}, 32'h0000_0220);
    rdchk(`OFS_ERASE_ENTRY, 32'h0000_0110, "erase entry");
    wr(`OFS_KEY, {24'h0, `KEY_PROG_ERASE});
    erase(8'h03);
    rdchk(`OFS_GREG_ZERO, 32'h0000_0008, "boot array erase");
    check("erase count", erase_cnt, 8'h00);
    wr(`OFS_ARRAY_SEL, {24'h0, `ARRAY_USER});
    wait_st(32'h0000_0010, 32'h0000_0000);
    check("boot visible", bav, 1'b0);
    erase(8'h03);
    check("erase count", erase_cnt, 8'h01);
    check("erase block", last_blk, 8'h03);
    rdchk(`OFS_GREG_ZERO, 32'h0, "reg zero");
    rdchk(`OFS_GREG_ONE, 32'h0, "reg one");
    lat <= 8'h14;
    erase(8'h07);
    check("erase block", last_blk, 8'h07);
    erase(8'h08);
    rdchk(`OFS_GREG_ZERO, 32'h0000_0001, "bad block");
    check("erase count", erase_cnt, 8'h02);
    wr(`OFS_KEY, 32'h0);
    wr(`OFS_ARRAY_SEL, {24'h0, `ARRAY_BOOT});
    wait_st(32'h0000_0010, 32'h0000_0000);
    check("boot visible", bav, 1'b1);
    xfer(1'b0, 8'h30, 32'h0);
    check("unmapped error", slv, 1'b1);
    check("unmapped data", rd, 32'h0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
